/* common/ocd_pkg.sv */
// Shared types and constants for the opcode decoder block
package ocd_pkg;

    // Register-file location of the status flags register
    localparam logic [7:0] OCD_FLAGS_ADDR  = 8'hD5;
    localparam logic [7:0] OCD_FLAGS_RESET = 8'h00;
    // Status flag bit positions
    localparam int OCD_FLAG_C_BIT = 7;
    localparam int OCD_FLAG_Z_BIT = 6;
    localparam int OCD_FLAG_S_BIT = 5;
    localparam int OCD_FLAG_V_BIT = 4;
    // Condition patterns with fixed meaning
    localparam logic [3:0] OCD_CC_NEVER  = 4'h0;
    localparam logic [3:0] OCD_CC_ALWAYS = 4'h8;
    // Memory address width (0..8191)
    localparam int OCD_MEM_AW = 13;
    // Decode result latency in clock cycles
    localparam int OCD_DEC_LAT = 1;

    // Operation classes
    typedef enum logic [5:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUBTRACT_WITH_CARRY,
        OP_OR, OP_AND, OP_TEST_COMPLEMENT_MASK, OP_TEST_UNDER_MASK,
        OP_COMPARE, OP_XOR, OP_DECREMENT, OP_ROTATE_LEFT_CARRY,
        OP_INCREMENT, OP_POP, OP_COMPLEMENT, OP_PUSH, OP_ROTATE_LEFT,
        OP_CLEAR, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH,
        OP_ROTATE_RIGHT, OP_JUMP_PAIR, OP_LOAD_INDEXED, OP_LOAD,
        OP_PROGRAM_MEM_LOAD, OP_PROGRAM_MEM_LOAD_DEC,
        OP_PROGRAM_MEM_LOAD_INC, OP_CALL, OP_JUMP_RELATIVE,
        OP_JUMP_COND, OP_INCREMENT_WORK, OP_IDLE, OP_STOP,
        OP_DISABLE_INT, OP_ENABLE_INT, OP_RETURN, OP_INTERRUPT_RETURN,
        OP_RESET_CARRY, OP_SET_CARRY, OP_COMPLEMENT_CARRY, OP_NOP,
        OP_UNDEFINED
    } ocd_op_e;

    // Operand addressing forms
    typedef enum logic [3:0] {
        AM_NONE, AM_WORK, AM_IND_WORK, AM_REG, AM_IND_REG,
        AM_IMMEDIATE_MODE, AM_PAIR_IND, AM_INDEXED,
        AM_SHORT_OFFSET_INDEXED, AM_LONG_OFFSET_INDEXED,
        AM_DIRECT_ADDRESS_MODE, AM_RELATIVE_ADDRESS_MODE
    } ocd_mode_e;

    // Per-flag effect of an instruction
    typedef enum logic [2:0] {
        FX_KEEP, FX_CLEAR, FX_SET, FX_UPDATE, FX_UNDEF
    } ocd_fx_e;

    // Flag effect for all four flags
    typedef struct packed {
        ocd_fx_e c;
        ocd_fx_e z;
        ocd_fx_e s;
        ocd_fx_e v;
    } ocd_fx_s;

    // Decoded first opcode byte
    typedef struct packed {
        ocd_op_e   op;
        ocd_mode_e dst;
        ocd_mode_e src;
        logic [3:0] nib;   // Working register number or condition code
        logic       undef;
        ocd_fx_s    fx;
    } ocd_dec_s;

    // Flag results offered by the datapath
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } ocd_alu_flags_s;

    // Operand bytes and context for address forming
    typedef struct packed {
        logic [7:0]            lo;      // First operand byte
        logic [7:0]            hi;      // Second byte of a long address
        logic [15:0]           pair;    // Contents of the register pair
        logic [OCD_MEM_AW-1:0] next_pc; // Address after this instruction
    } ocd_opnd_s;

endpackage

/* core/ocd_cond_eval.sv */
// Condition code evaluation against the status flags
`timescale 1ns/1ps
module ocd_cond_eval
    import ocd_pkg::*;
(
    input  wire logic [3:0] cc,
    input  wire logic [7:0] flags,
    output logic            take
);
    // Flag taps
    wire fc = flags[OCD_FLAG_C_BIT];
    wire fz = flags[OCD_FLAG_Z_BIT];
    wire fs = flags[OCD_FLAG_S_BIT];
    wire fv = flags[OCD_FLAG_V_BIT];
    // Low three bits pick the test, bit 3 inverts it
    logic base;

    // Base test for each pattern family
    always_comb begin
        case (cc[2:0])
            3'h0: base = 1'b0;             // Never, inverted to always
            3'h1: base = fs ^ fv;          // Less than
            3'h2: base = fz | (fs ^ fv);   // Less or equal
            3'h3: base = fc | fz;          // Unsigned less or equal
            3'h4: base = fv;               // Overflow
            3'h5: base = fs;               // Minus
            3'h6: base = fz;               // Zero
            3'h7: base = fc;               // Carry
            default: base = 1'b0;
        endcase
    end

    // Pattern 0000 never jumps and 1000 always does
    assign take = cc[3] ? ~base : base;

endmodule // ocd_cond_eval

/* core/ocd_decoder.sv */
// Opcode decoder with operand forming and status flags register
// What this block does
// - Low nibbles 2-6 pick two-operand forms
// - Upper nibble picks two-operand operation
// - Nibbles 0/1 single-operand; 30 pair jump
// - Low nibble 7 decodes indexed loads
// - Nibbles 8,9,B,C,D,E fixed column ops
// - Special loads, stores and calls recognised
// - Register 0-255, working register 0-15
// - Pairs use even base addresses
// - Short index adds signed byte offset
// - Long index and direct: 13-bit addresses
// - Relative jump adds to next address
// - Immediate is one unsigned byte
// - Each flag follows instruction flag effect
// - Flags: C7, Z6, S5, V4
// - Four-bit condition; 0000 never, 1000 always
`timescale 1ns/1ps
module ocd_decoder
    import ocd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  op_valid,
    input  wire logic [7:0]            op_byte,
    input  wire logic                  opnd_valid,
    input  wire ocd_opnd_s             opnd,
    input  wire logic                  alu_valid,
    input  wire ocd_alu_flags_s        alu_flags,
    input  wire logic                  rf_wr,
    input  wire logic                  rf_rd,
    input  wire logic [7:0]            rf_addr,
    input  wire logic [7:0]            rf_wdata,
    output logic [7:0]                 rf_rdata,
    output logic                       dec_valid,
    output ocd_dec_s                   dec,
    output logic [7:0]                 status_flags,
    output logic                       cond_take,
    output logic [OCD_MEM_AW-1:0]      eff_addr,
    output logic [7:0]                 imm_data,
    output logic [7:0]                 pair_base,
    output logic                       pair_odd_err
);

    // Flag effect of an operation
    function automatic ocd_fx_s flag_fx(input ocd_op_e op);
        ocd_fx_s f;
        f = '{FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP};
        case (op)
            OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUBTRACT_WITH_CARRY,
            OP_COMPARE, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
            OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_INTERRUPT_RETURN:
                f = '{FX_UPDATE, FX_UPDATE, FX_UPDATE, FX_UPDATE};
            OP_OR, OP_AND, OP_XOR, OP_TEST_COMPLEMENT_MASK,
            OP_TEST_UNDER_MASK, OP_COMPLEMENT:
                f = '{FX_KEEP, FX_UPDATE, FX_UPDATE, FX_CLEAR};
            OP_SHIFT_RIGHT_ARITH:
                f = '{FX_UPDATE, FX_UPDATE, FX_UPDATE, FX_CLEAR};
            OP_DECREMENT, OP_INCREMENT, OP_INCREMENT_WORK:
                f = '{FX_KEEP, FX_UPDATE, FX_UPDATE, FX_UPDATE};
            OP_RESET_CARRY:      f.c = FX_CLEAR;
            OP_SET_CARRY:        f.c = FX_SET;
            OP_COMPLEMENT_CARRY: f.c = FX_UPDATE;
            default:             f = f;
        endcase
        return f;
    endfunction

    // Two-operand family operation by upper nibble
    function automatic ocd_op_e alu_op(input logic [3:0] up);
        case (up)
            4'h0: return OP_ADD;
            4'h1: return OP_ADD_CARRY;
            4'h2: return OP_SUBTRACT;
            4'h3: return OP_SUBTRACT_WITH_CARRY;
            4'h4: return OP_OR;
            4'h5: return OP_AND;
            4'h6: return OP_TEST_COMPLEMENT_MASK;
            4'h7: return OP_TEST_UNDER_MASK;
            4'hA: return OP_COMPARE;
            4'hB: return OP_XOR;
            default: return OP_UNDEFINED;
        endcase
    endfunction

    // Single-operand operation by upper nibble
    function automatic ocd_op_e one_op(input logic [3:0] up);
        case (up)
            4'h0: return OP_DECREMENT;
            4'h1: return OP_ROTATE_LEFT_CARRY;
            4'h2: return OP_INCREMENT;
            4'h5: return OP_POP;
            4'h6: return OP_COMPLEMENT;
            4'h7: return OP_PUSH;
            4'h9: return OP_ROTATE_LEFT;
            4'hB: return OP_CLEAR;
            4'hC: return OP_ROTATE_RIGHT_CARRY;
            4'hD: return OP_SHIFT_RIGHT_ARITH;
            4'hE: return OP_ROTATE_RIGHT;
            default: return OP_UNDEFINED;
        endcase
    endfunction

    // Control opcodes of the last column
    function automatic ocd_op_e ctl_op(input logic [3:0] up);
        case (up)
            4'h6: return OP_IDLE;
            4'h7: return OP_STOP;
            4'h8: return OP_DISABLE_INT;
            4'h9: return OP_ENABLE_INT;
            4'hA: return OP_RETURN;
            4'hB: return OP_INTERRUPT_RETURN;
            4'hC: return OP_RESET_CARRY;
            4'hD: return OP_SET_CARRY;
            4'hE: return OP_COMPLEMENT_CARRY;
            4'hF: return OP_NOP;
            default: return OP_UNDEFINED;
        endcase
    endfunction

    // Full decode of the first opcode byte
    function automatic ocd_dec_s decode(input logic [7:0] b);
        ocd_dec_s d;
        logic [3:0] up;
        logic [3:0] lo;
        up = b[7:4];
        lo = b[3:0];
        d = '{OP_UNDEFINED, AM_NONE, AM_NONE, up, 1'b0,
              '{FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP}};
        case (lo)
            4'h0, 4'h1: begin
                d.op  = one_op(up);
                d.dst = lo[0] ? AM_IND_REG : AM_REG;
                if (b == 8'h30) begin
                    d.op  = OP_JUMP_PAIR;
                    d.dst = AM_PAIR_IND;
                end
            end
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
                d.op = alu_op(up);
                case (lo)
                    4'h2: begin d.dst = AM_WORK; d.src = AM_WORK; end
                    4'h3: begin d.dst = AM_WORK; d.src = AM_IND_WORK; end
                    4'h4: begin d.dst = AM_REG;  d.src = AM_REG; end
                    4'h5: begin d.dst = AM_REG;  d.src = AM_IND_REG; end
                    default: begin
                        d.dst = AM_REG;
                        d.src = AM_IMMEDIATE_MODE;
                    end
                endcase
                case (b)
                    8'hE2: d.op = OP_PROGRAM_MEM_LOAD_DEC;
                    8'hE3: d.op = OP_PROGRAM_MEM_LOAD_INC;
                    8'hC3, 8'hD3: d.op = OP_PROGRAM_MEM_LOAD;
                    8'hE4, 8'hE5, 8'hE6, 8'hF5: d.op = OP_LOAD;
                    8'hD6: begin
                        d.op  = OP_LOAD;
                        d.dst = AM_IND_REG;
                    end
                    8'hF4, 8'hF6: d.op = OP_CALL;
                    default: d.op = d.op;
                endcase
                if (b inside {8'hE2, 8'hE3, 8'hC3, 8'hD3})
                    d.src = AM_PAIR_IND;
                if (b == 8'hF4) begin
                    d.dst = AM_PAIR_IND;
                    d.src = AM_NONE;
                end
                if (b == 8'hF6) begin
                    d.dst = AM_DIRECT_ADDRESS_MODE;
                    d.src = AM_NONE;
                end
                if (b == 8'hF5)
                    d.dst = AM_IND_REG;
            end
            4'h7: begin
                d.dst = AM_WORK;
                case (up)
                    4'h8, 4'h9: begin
                        d.op = OP_LOAD_INDEXED;
                        d.src = AM_INDEXED;
                    end
                    4'hA, 4'hB: begin
                        d.op = OP_PROGRAM_MEM_LOAD;
                        d.src = AM_LONG_OFFSET_INDEXED;
                    end
                    4'hC, 4'hD: begin
                        d.op = OP_LOAD;
                        d.src = AM_IND_WORK;
                    end
                    4'hE, 4'hF: begin
                        d.op = OP_PROGRAM_MEM_LOAD;
                        d.src = AM_SHORT_OFFSET_INDEXED;
                    end
                    default: d.dst = AM_NONE;
                endcase
            end
            4'h8: begin d.op = OP_LOAD; d.dst = AM_WORK; d.src = AM_REG; end
            4'h9: begin d.op = OP_LOAD; d.dst = AM_REG; d.src = AM_WORK; end
            4'hB: begin
                d.op  = OP_JUMP_RELATIVE;
                d.dst = AM_RELATIVE_ADDRESS_MODE;
            end
            4'hC: begin
                d.op  = OP_LOAD;
                d.dst = AM_WORK;
                d.src = AM_IMMEDIATE_MODE;
            end
            4'hD: begin
                d.op  = OP_JUMP_COND;
                d.dst = AM_DIRECT_ADDRESS_MODE;
            end
            4'hE: begin d.op = OP_INCREMENT_WORK; d.dst = AM_WORK; end
            4'hF: d.op = ctl_op(up);
            default: d.op = OP_UNDEFINED; // Column A is blank
        endcase
        d.undef = (d.op == OP_UNDEFINED);
        if (d.undef) begin
            d.dst = AM_NONE;
            d.src = AM_NONE;
        end
        d.fx = flag_fx(d.op);
        return d;
    endfunction

    // Apply one flag effect to one flag bit
    function automatic logic fx_apply(input ocd_fx_e fx, input logic cur,
                                      input logic res);
        case (fx)
            FX_CLEAR:  return 1'b0;
            FX_SET:    return 1'b1;
            FX_UPDATE: return res;
            default:   return cur; // Undefined leaves the old value
        endcase
    endfunction

    // Signed byte added to a 13-bit base
    function automatic logic [OCD_MEM_AW-1:0] add_sext(
            input logic [OCD_MEM_AW-1:0] base, input logic [7:0] off);
        return base + {{(OCD_MEM_AW-8){off[7]}}, off};
    endfunction

    // Registers
    ocd_dec_s                 dec_reg;
    logic                     dec_valid_reg;
    logic [7:0]               flags_reg;
    logic [7:0]               flags_next;
    logic [7:0]               rdata_reg;
    logic                     take_reg;
    logic [OCD_MEM_AW-1:0]    addr_reg;
    logic [7:0]               imm_reg;
    logic [7:0]               pair_reg;
    logic                     pair_err_reg;

    // Decode of the incoming byte and register-file select
    wire ocd_dec_s dec_now  = decode(op_byte);
    wire           flags_sel = (rf_addr == OCD_FLAGS_ADDR);
    wire           take_now;
    // Long and direct addresses keep only 13 bits
    wire [OCD_MEM_AW-1:0] long_addr =
        {opnd.hi[OCD_MEM_AW-9:0], opnd.lo};
    wire [OCD_MEM_AW-1:0] pair_addr = opnd.pair[OCD_MEM_AW-1:0];
    wire [OCD_MEM_AW-1:0] addr_now =
        (dec_reg.src == AM_SHORT_OFFSET_INDEXED) ?
            add_sext(pair_addr, opnd.lo) :
        (dec_reg.src == AM_LONG_OFFSET_INDEXED) ?
            pair_addr + long_addr :
        (dec_reg.dst == AM_RELATIVE_ADDRESS_MODE) ?
            add_sext(opnd.next_pc, opnd.lo) :
        long_addr;
    // Pair operands are even; an odd byte is flagged
    wire pair_form = (dec_reg.dst == AM_PAIR_IND) ||
                     (dec_reg.src == AM_PAIR_IND);

    // Condition test uses the flags register bits
    ocd_cond_eval u_cond (
        .cc    (dec_reg.nib),
        .flags (flags_reg),
        .take  (take_now)
    );

    // Next flags: software write first, datapath update wins
    always_comb begin
        flags_next = flags_reg;
        if (rf_wr && flags_sel)
            flags_next = rf_wdata;
        if (alu_valid) begin
            flags_next[OCD_FLAG_C_BIT] = fx_apply(dec_reg.fx.c,
                flags_reg[OCD_FLAG_C_BIT], alu_flags.c);
            flags_next[OCD_FLAG_Z_BIT] = fx_apply(dec_reg.fx.z,
                flags_reg[OCD_FLAG_Z_BIT], alu_flags.z);
            flags_next[OCD_FLAG_S_BIT] = fx_apply(dec_reg.fx.s,
                flags_reg[OCD_FLAG_S_BIT], alu_flags.s);
            flags_next[OCD_FLAG_V_BIT] = fx_apply(dec_reg.fx.v,
                flags_reg[OCD_FLAG_V_BIT], alu_flags.v);
        end
    end

    // Decode stage register
    always_ff @(posedge clk) begin
        if (rst) begin
            dec_valid_reg <= 1'b0;
            dec_reg       <= '{OP_NOP, AM_NONE, AM_NONE, 4'h0, 1'b0,
                               '{FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP}};
        end else begin
            dec_valid_reg <= op_valid;
            if (op_valid)
                dec_reg <= dec_now;
        end
    end

    // Flags register, read port and condition result
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= OCD_FLAGS_RESET;
            rdata_reg <= 8'h00;
            take_reg  <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            if (rf_rd)
                rdata_reg <= flags_sel ? flags_reg : 8'h00;
            take_reg <= take_now;
        end
    end

    // Operand forming, captured when operand bytes arrive
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg     <= '0;
            imm_reg      <= 8'h00;
            pair_reg     <= 8'h00;
            pair_err_reg <= 1'b0;
        end else if (opnd_valid) begin
            addr_reg     <= addr_now;
            imm_reg      <= opnd.lo;
            pair_reg     <= {opnd.lo[7:1], 1'b0};
            pair_err_reg <= pair_form & opnd.lo[0];
        end
    end

    assign dec_valid    = dec_valid_reg;
    assign dec          = dec_reg;
    assign status_flags = flags_reg;
    assign rf_rdata     = rdata_reg;
    assign cond_take    = take_reg;
    assign eff_addr     = addr_reg;
    assign imm_data     = imm_reg;
    assign pair_base    = pair_reg;
    assign pair_odd_err = pair_err_reg;

    // Checks on the decode and the flags
    a_decode_latency: assert property (@(posedge clk) disable iff (rst)
        op_valid |=> dec_valid && dec.nib == $past(op_byte[7:4]))
        else $error("decode did not follow opcode by one cycle");
    a_alu_add_form: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_byte == 8'h02 |=>
            dec.op == OP_ADD && dec.dst == AM_WORK && dec.src == AM_WORK)
        else $error("opcode 02 not decoded as add working pair");
    a_pair_jump: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_byte == 8'h30 |=> dec.op == OP_JUMP_PAIR)
        else $error("opcode 30 not decoded as pair jump");
    a_column_a_undef: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_byte[3:0] == 4'hA |=> dec.undef)
        else $error("blank column not undefined");
    a_ctl_nop: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_byte == 8'hFF |=> dec.op == OP_NOP && !dec.undef)
        else $error("opcode FF not decoded as no operation");
    a_set_carry: assert property (@(posedge clk) disable iff (rst)
        alu_valid && dec.op == OP_SET_CARRY |=> flags_reg[OCD_FLAG_C_BIT])
        else $error("set carry did not set the carry flag");
    a_logic_v_clear: assert property (@(posedge clk) disable iff (rst)
        alu_valid && dec.op == OP_AND |=>
            !flags_reg[OCD_FLAG_V_BIT] &&
            flags_reg[OCD_FLAG_Z_BIT] == $past(alu_flags.z))
        else $error("logic op flag effect wrong");
    a_flags_write: assert property (@(posedge clk) disable iff (rst)
        rf_wr && flags_sel && !alu_valid |=> flags_reg == $past(rf_wdata))
        else $error("flags register write lost");
    a_cond_fixed: assert property (@(posedge clk) disable iff (rst)
        (dec.nib == OCD_CC_NEVER |=> !cond_take) and
        (dec.nib == OCD_CC_ALWAYS |=> cond_take))
        else $error("fixed condition codes wrong");
    a_pair_even: assert property (@(posedge clk) disable iff (rst)
        opnd_valid |=> !pair_base[0] &&
            pair_odd_err == ($past(pair_form) && $past(opnd.lo[0])))
        else $error("pair base not even or error wrong");
    a_rel_target: assert property (@(posedge clk) disable iff (rst)
        opnd_valid && dec.dst == AM_RELATIVE_ADDRESS_MODE && !op_valid |=>
            eff_addr == $past(opnd.next_pc) +
                {{5{$past(opnd.lo[7])}}, $past(opnd.lo)})
        else $error("relative target not from next address");

endmodule // ocd_decoder

/* sim/tb.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb;
    import ocd_pkg::*;
    logic           clk = 0, rst = 1, op_valid = 0, opnd_valid = 0;
    logic           alu_valid = 0, rf_wr = 0, rf_rd = 0;
    logic           dec_valid, cond_take, pair_odd_err;
    logic [7:0]     op_byte = 0, rf_addr = 0, rf_wdata = 0;
    logic [7:0]     rf_rdata, status_flags, imm_data, pair_base;
    logic [12:0]    eff_addr;
    ocd_opnd_s      opnd = '0;
    ocd_alu_flags_s alu_flags = '0;
    ocd_dec_s       dec;
    int             error_cnt = 0, compares = 0;
    // Modes of the two-operand columns 2 to 6
    ocd_mode_e md_d [5] = '{AM_WORK, AM_WORK, AM_REG, AM_REG, AM_REG};
    ocd_mode_e md_s [5] = '{AM_WORK, AM_IND_WORK, AM_REG, AM_IND_REG,
                            AM_IMMEDIATE_MODE};
    // Taken codes under flags A5 (C=1 Z=0 S=1 V=0), one bit per code
    localparam logic [15:0] CC_EXP = 16'h51AE;
    // Opcode bytes and the operation each must decode to
    localparam int N = 59;
    logic [7:0] tv_b [N] = '{8'h02, 8'h12, 8'h22, 8'h32, 8'h42, 8'h56,
        8'h63, 8'h74, 8'hA5, 8'hB6, 8'h00, 8'h11, 8'h20, 8'h51, 8'h60,
        8'h71, 8'h90, 8'hB1, 8'hC0, 8'hD1, 8'hE0, 8'h30, 8'h87, 8'h97,
        8'hA7, 8'hB7, 8'hC7, 8'hD7, 8'hE7, 8'hF7, 8'hD6, 8'h08, 8'hF9,
        8'h7B, 8'hAC, 8'h3D, 8'hFE, 8'hE2, 8'hE3, 8'hC3, 8'hD3, 8'hE4,
        8'hE5, 8'hE6, 8'hF5, 8'hF4, 8'hF6, 8'h6F, 8'h7F, 8'h8F, 8'h9F,
        8'hAF, 8'hBF, 8'hCF, 8'hDF, 8'hEF, 8'hFF, 8'h40, 8'h1A};
    ocd_op_e tv_o [N] = '{OP_ADD, OP_ADD_CARRY, OP_SUBTRACT,
        OP_SUBTRACT_WITH_CARRY, OP_OR, OP_AND, OP_TEST_COMPLEMENT_MASK,
        OP_TEST_UNDER_MASK, OP_COMPARE, OP_XOR, OP_DECREMENT,
        OP_ROTATE_LEFT_CARRY, OP_INCREMENT, OP_POP, OP_COMPLEMENT,
        OP_PUSH, OP_ROTATE_LEFT, OP_CLEAR, OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH, OP_ROTATE_RIGHT, OP_JUMP_PAIR,
        OP_LOAD_INDEXED, OP_LOAD_INDEXED, OP_PROGRAM_MEM_LOAD,
        OP_PROGRAM_MEM_LOAD, OP_LOAD, OP_LOAD, OP_PROGRAM_MEM_LOAD,
        OP_PROGRAM_MEM_LOAD, OP_LOAD, OP_LOAD, OP_LOAD, OP_JUMP_RELATIVE,
        OP_LOAD, OP_JUMP_COND, OP_INCREMENT_WORK, OP_PROGRAM_MEM_LOAD_DEC,
        OP_PROGRAM_MEM_LOAD_INC, OP_PROGRAM_MEM_LOAD, OP_PROGRAM_MEM_LOAD,
        OP_LOAD, OP_LOAD, OP_LOAD, OP_LOAD, OP_CALL, OP_CALL, OP_IDLE,
        OP_STOP, OP_DISABLE_INT, OP_ENABLE_INT, OP_RETURN,
        OP_INTERRUPT_RETURN, OP_RESET_CARRY, OP_SET_CARRY,
        OP_COMPLEMENT_CARRY, OP_NOP, OP_UNDEFINED, OP_UNDEFINED};

    ocd_decoder DUT (.clk, .rst, .op_valid, .op_byte, .opnd_valid, .opnd,
        .alu_valid, .alu_flags, .rf_wr, .rf_rd, .rf_addr, .rf_wdata,
        .rf_rdata, .dec_valid, .dec, .status_flags, .cond_take, .eff_addr,
        .imm_data, .pair_base, .pair_odd_err);

    // 250 MHz clock
    always #2 clk = ~clk;

    // Four-state compare; an unknown matches only an identical unknown
    task automatic chk(input logic [15:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Each access is one cycle wide, launched off the falling edge
    task automatic dcd(input logic [7:0] b);
        @(negedge clk);
        op_valid = 1;
        op_byte = b;
        @(negedge clk);
        op_valid = 0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        rf_wr = 1;
        rf_addr = a;
        rf_wdata = d;
        @(negedge clk);
        rf_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk);
        rf_rd = 1;
        rf_addr = a;
        @(negedge clk);
        rf_rd = 0;
        chk(rf_rdata, e, "read");
    endtask
    task automatic opr(input logic [7:0] lo, hi, input logic [15:0] pr,
                       input logic [12:0] pc);
        @(negedge clk);
        opnd_valid = 1;
        opnd = '{lo, hi, pr, pc};
        @(negedge clk);
        opnd_valid = 0;
    endtask
    task automatic alu(input logic [3:0] f);
        @(negedge clk);
        alu_valid = 1;
        alu_flags = f;
        @(negedge clk);
        alu_valid = 0;
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst = 0;
        chk(status_flags, OCD_FLAGS_RESET, "rst");
        chk(dec_valid, 0, "rst valid");
        // Back-to-back decode, one opcode every cycle
        for (int i = 0; i <= N; i++) begin
            @(negedge clk);
            if (i > 0) begin
                chk(dec_valid, 1, "valid");
                chk(dec.op, tv_o[i-1], "op");
                chk(dec.nib, tv_b[i-1][7:4], "nib");
                chk(dec.undef, tv_o[i-1] == OP_UNDEFINED, "undef");
            end
            op_valid = (i < N);
            op_byte = tv_b[i % N];
        end
        @(negedge clk);
        chk(dec_valid, 0, "valid low");
        for (int i = 2; i < 7; i++) begin
            dcd(8'(8'hA0 + i));
            chk(dec.dst, md_d[i-2], "dst");
            chk(dec.src, md_s[i-2], "src");
        end
        $display("done: decode");
        // Flags register by address, other addresses absent
        wr(OCD_FLAGS_ADDR, 8'hA5);
        chk(status_flags, 8'hA5, "flags");
        rd(OCD_FLAGS_ADDR, 8'hA5);
        wr(8'hD4, 8'h3C);
        rd(8'hD4, 8'h00);
        chk(status_flags, 8'hA5, "kept");
        $display("done: flags");
        // Every condition code against the flags
        for (int c = 0; c < 16; c++) begin
            dcd({4'(c), 4'hB});
            @(negedge clk);
            chk(cond_take, CC_EXP[c], "cond");
        end
        $display("done: conditions");
        // Operand forming, wrap at 8192
        dcd(8'h0B);
        opr(8'hFE, 8'h00, 16'h0000, 13'h0100);
        chk(eff_addr, 13'h00FE, "rel");
        opr(8'h7F, 8'h00, 16'h0000, 13'h1FFF);
        chk(eff_addr, 13'h007E, "rel wrap");
        dcd(8'hE7);
        opr(8'h80, 8'h00, 16'h0010, 13'h0000);
        chk(eff_addr, 13'h1F90, "short");
        dcd(8'hA7);
        opr(8'hFF, 8'h1F, 16'h0100, 13'h0000);
        chk(eff_addr, 13'h00FF, "long");
        dcd(8'hF6);
        opr(8'hFF, 8'hFF, 16'h0000, 13'h0000);
        chk(eff_addr, 13'h1FFF, "direct");
        dcd(8'h06);
        opr(8'hFF, 8'h00, 16'h0000, 13'h0000);
        chk(imm_data, 8'hFF, "imm");
        dcd(8'hC3);
        opr(8'hFF, 8'h00, 16'h0000, 13'h0000);
        chk(pair_base, 8'hFE, "odd base");
        chk(pair_odd_err, 1, "odd flag");
        opr(8'hFE, 8'h00, 16'h0000, 13'h0000);
        chk(pair_odd_err, 0, "even flag");
        $display("done: operands");
        // Flag effects: logic op, set carry, reset carry
        wr(OCD_FLAGS_ADDR, 8'hF0);
        dcd(8'h52);
        chk(dec.fx, {FX_KEEP, FX_UPDATE, FX_UPDATE, FX_CLEAR}, "fx");
        alu(4'b0011);
        chk(status_flags, 8'hA0, "logic fx");
        wr(OCD_FLAGS_ADDR, 8'h00);
        dcd(8'hDF);
        alu(4'b0000);
        chk(status_flags, 8'h80, "set c");
        dcd(8'hCF);
        alu(4'b1111);
        chk(status_flags, 8'h00, "reset c");
        $display("done: flag effects");
        close_out;
    end

    // A hang is cut well past the under two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out;
    end
endmodule // tb
